// File: t16b_defs.vh
// Constants for the 16-bit timer register block
// Function
// - Writing a compare buffer sets that channel's buffer-valid bit.
// - Period buffer write sets its valid bit; an update clears it.
// - An update clears all compare buffer-valid bits.
// - Writing ones to the set register sets those bits; zeros change nothing.
// - Event action 0 counts rising event edges, action 1 counts every edge.
// - Event action 2 counts prescaled ticks while the event line is high.
// - Event action 3 counts ticks, up on event low, down on event high.
// - The event line steers counting only when count-on-event is enabled.
// - Enable bits 4 to 6 gate the compare interrupt of channels 0 to 2.
// - Enable bit 0 gates the overflow/underflow interrupt.
// - A compare flag sets whenever the counter equals that compare value.
// - Compare flags stay set until software writes a one to them.
// - Overflow flag sets at TOP or BOTTOM per mode; cleared by writing one.
// - Run-in-debug set keeps counting during a debug halt; clear stops it.
// - One shared software-visible temporary byte serves all 16-bit accesses.
// - Each 16-bit register has low byte at base, high byte at base plus one.
// - A software counter write wins over a same-cycle internal count change.
// - The period register holds the TOP value in all modes but frequency mode (TOP is compare 0 there) and resets to all ones.
// - An update loads each compare register whose buffer-valid bit is set from its compare buffer.
// - While lock-update is one, updates move no buffered value.
`ifndef T16B_DEFS_VH
`define T16B_DEFS_VH

`define T16B_A_FCLR 6'h06
`define T16B_A_FSET 6'h07
`define T16B_A_EVCTL 6'h09
`define T16B_A_INTEN 6'h0a
`define T16B_A_INTFL 6'h0b
`define T16B_A_DBG 6'h0e
`define T16B_A_TEMP 6'h0f
`define T16B_A_CNT 6'h20
`define T16B_A_PER 6'h26
`define T16B_A_CMP 6'h28
`define T16B_A_PERBUF 6'h36
`define T16B_A_CMPBUF 6'h38
`define T16B_CH_STRIDE 6'h02
`define T16B_WORD_MASK 6'h3e

`define T16B_NCH 3
`define T16B_BV_PER 0
`define T16B_BV_CMP0 1
`define T16B_IE_OVF 0
`define T16B_IE_CMP0 4
`define T16B_EV_COUNT_ON_EVENT_ENABLE 0
`define T16B_EV_ACT_HI 2
`define T16B_EV_ACT_LO 1
`define T16B_DBG_RUN 0

`define T16B_ACT_POSEDGE 2'h0
`define T16B_ACT_ANYEDGE 2'h1
`define T16B_ACT_HIGHLVL 2'h2
`define T16B_ACT_UPDOWN 2'h3

`define T16B_WG_NORMAL 3'h0
`define T16B_WG_FRQ 3'h1
`define T16B_WG_SINGLE 3'h3
`define T16B_WG_DSTOP 3'h5
`define T16B_WG_DSBOTH 3'h6
`define T16B_WG_DSBOTTOM 3'h7

`define T16B_PER_RST 16'hffff
`define T16B_ZERO16 16'h0000
`define T16B_ONE16 16'h0001
`define T16B_ZERO8 8'h00
`define T16B_ZERO4 4'h0

`endif

// File: t16b_cmp_chan.v
// One compare channel: compare value, its buffer, valid bit and match flag
`timescale 1ns/10ps
`include "t16b_defs.vh"
module t16b_cmp_chan (
    input wire mclk,
    input wire rst,
    input wire [15:0] cnt,
    input wire [15:0] wr_word,
    input wire buf_wr,
    input wire cmp_wr,
    input wire bv_set,
    input wire bv_clr,
    input wire update_go,
    input wire flag_clr,
    output reg [15:0] cmp_q,
    output reg [15:0] buf_q,
    output reg bv_q,
    output reg flag_q
);
    always @(posedge mclk) begin
        if (rst) begin
            cmp_q <= `T16B_ZERO16;
            buf_q <= `T16B_ZERO16;
            bv_q <= 1'b0;
            flag_q <= 1'b0;
        end else begin
            if (buf_wr)
                buf_q <= wr_word;
            // Set terms win over the update and software clears
            bv_q <= buf_wr | bv_set | (bv_q & ~update_go & ~bv_clr);
            // A direct software write beats the buffered transfer
            if (cmp_wr)
                cmp_q <= wr_word;
            else if (update_go && bv_q)
                cmp_q <= buf_q;
            // Level compare: a stopped counter sitting on the value re-flags
            flag_q <= (cnt == cmp_q) | (flag_q & ~flag_clr);
        end
    end
endmodule

// File: t16b_timer.v
// 16-bit timer/counter: byte register port, counting engine and event input
`timescale 1ns/10ps
`include "t16b_defs.vh"
module t16b_timer (
    input wire mclk,
    input wire rst,
    input wire [5:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire event_in,
    input wire prescale_tick,
    input wire timer_enable,
    input wire [2:0] waveform_mode,
    input wire lock_update,
    input wire force_update,
    input wire debug_halt,
    output wire irq_ovf,
    output wire [2:0] irq_cmp,
    output wire count_down
);
    reg [15:0] cnt_q;
    reg [15:0] cnt_d;
    reg [15:0] per_q;
    reg [15:0] perbuf_q;
    reg period_buffer_valid_q;
    reg [2:0] evctl_q;
    reg ie_ovf_q;
    reg [2:0] ie_cmp_q;
    reg ovf_flag_q;
    reg dbg_run_q;
    reg [7:0] temp_q;
    reg dir_q;
    reg dir_d;
    reg ev_s1_q;
    reg ev_s2_q;
    reg ev_s3_q;
    reg ev_lvl_q;
    reg ev_prev_q;

    wire [47:0] cmp_all;
    wire [47:0] buf_all;
    wire [2:0] bv_all;
    wire [2:0] flag_all;

    wire [5:0] word_base = reg_addr & `T16B_WORD_MASK;
    wire hi_byte = reg_addr[0];
    wire [15:0] wr_word = {reg_wdata, temp_q};
    // A high-byte write commits the whole word with the latched low byte
    wire wr16 = reg_wr & hi_byte;

    wire wr_fset = reg_wr && (reg_addr == `T16B_A_FSET);
    wire wr_fclr = reg_wr && (reg_addr == `T16B_A_FCLR);
    wire wr_intfl = reg_wr && (reg_addr == `T16B_A_INTFL);
    wire wr_cnt = wr16 && (word_base == `T16B_A_CNT);
    wire wr_per = wr16 && (word_base == `T16B_A_PER);
    wire wr_perbuf = wr16 && (word_base == `T16B_A_PERBUF);

    wire cnt_on_ev = evctl_q[`T16B_EV_COUNT_ON_EVENT_ENABLE];
    wire [1:0] ev_act = evctl_q[`T16B_EV_ACT_HI:`T16B_EV_ACT_LO];
    // Edges come from the accepted level, which idles low like the line after reset
    wire ev_rise = ev_lvl_q & ~ev_prev_q;
    wire ev_fall = ~ev_lvl_q & ev_prev_q;

    // Event line comes from outside this clock: three stages, accept on agreement
    always @(posedge mclk) begin
        if (rst) begin
            ev_s1_q <= 1'b0;
            ev_s2_q <= 1'b0;
            ev_s3_q <= 1'b0;
            ev_lvl_q <= 1'b0;
            ev_prev_q <= 1'b0;
        end else begin
            ev_s1_q <= event_in;
            ev_s2_q <= ev_s1_q;
            ev_s3_q <= ev_s2_q;
            if (ev_s2_q == ev_s3_q)
                ev_lvl_q <= ev_s3_q;
            ev_prev_q <= ev_lvl_q;
        end
    end

    reg ev_step;
    reg step;
    reg down;
    reg dual;
    reg top_ev;
    reg bot_ev;
    reg ovf_ev;
    reg upd_ev;
    reg [15:0] top_val;
    // Debug halt freezes counting unless run-in-debug is set
    wire run = timer_enable & (~debug_halt | dbg_run_q);
    wire [15:0] cnt_inc = cnt_q + `T16B_ONE16;
    wire [15:0] cnt_dec = cnt_q - `T16B_ONE16;

    always @* begin
        case (ev_act)
            `T16B_ACT_POSEDGE: ev_step = ev_rise;
            `T16B_ACT_ANYEDGE: ev_step = ev_rise | ev_fall;
            `T16B_ACT_HIGHLVL: ev_step = prescale_tick & ev_lvl_q;
            default: ev_step = prescale_tick;
        endcase
        step = run & (cnt_on_ev ? ev_step : prescale_tick);
        down = (cnt_on_ev && ev_act == `T16B_ACT_UPDOWN) ? ev_lvl_q : dir_q;
        // Dual-slope modes reverse at TOP and BOTTOM instead of wrapping
        dual = (waveform_mode == `T16B_WG_DSTOP) || (waveform_mode == `T16B_WG_DSBOTH) ||
               (waveform_mode == `T16B_WG_DSBOTTOM);
        top_val = (waveform_mode == `T16B_WG_FRQ) ? cmp_all[15:0] : per_q;
        cnt_d = cnt_q;
        // In event up/down mode the held direction follows the event level
        dir_d = down;
        top_ev = 1'b0;
        bot_ev = 1'b0;
        if (step) begin
            if (!down) begin
                if (cnt_q >= top_val) begin
                    top_ev = 1'b1;
                    if (dual) begin
                        dir_d = 1'b1;
                        cnt_d = cnt_dec;
                    end else begin
                        cnt_d = `T16B_ZERO16;
                    end
                end else begin
                    cnt_d = cnt_inc;
                end
            end else begin
                if (cnt_q == `T16B_ZERO16) begin
                    bot_ev = 1'b1;
                    if (dual) begin
                        dir_d = 1'b0;
                        cnt_d = `T16B_ONE16;
                    end else begin
                        cnt_d = top_val;
                    end
                end else begin
                    cnt_d = cnt_dec;
                end
            end
        end
        // Software write drops the internal step and any wrap it caused
        if (wr_cnt) begin
            cnt_d = wr_word;
            dir_d = down;
            top_ev = 1'b0;
            bot_ev = 1'b0;
        end
        case (waveform_mode)
            `T16B_WG_DSTOP: begin
                ovf_ev = top_ev;
                upd_ev = bot_ev;
            end
            `T16B_WG_DSBOTH: begin
                ovf_ev = top_ev | bot_ev;
                upd_ev = top_ev;
            end
            `T16B_WG_DSBOTTOM: begin
                ovf_ev = bot_ev;
                upd_ev = bot_ev;
            end
            default: begin
                // Single-slope modes: the wrap is both the overflow and the update
                ovf_ev = top_ev | bot_ev;
                upd_ev = top_ev | bot_ev;
            end
        endcase
    end

    // A locked update moves nothing and leaves every valid bit standing
    wire update_go = (upd_ev | force_update) & ~lock_update;

    reg [2:0] cmp_wr;
    reg [2:0] buf_wr;
    reg [5:0] cmp_ofs;
    reg [5:0] buf_ofs;
    integer ch;
    reg [5:0] rd_ofs;
    integer rch;
    // Channel words sit at a fixed stride above the first compare address
    always @* begin
        cmp_ofs = `T16B_A_CMP;
        buf_ofs = `T16B_A_CMPBUF;
        for (ch = 0; ch < `T16B_NCH; ch = ch + 1) begin
            cmp_wr[ch] = wr16 && (word_base == cmp_ofs);
            buf_wr[ch] = wr16 && (word_base == buf_ofs);
            cmp_ofs = cmp_ofs + `T16B_CH_STRIDE;
            buf_ofs = buf_ofs + `T16B_CH_STRIDE;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `T16B_NCH; gi = gi + 1) begin : g_ch
            t16b_cmp_chan u_chan (
                .mclk(mclk),
                .rst(rst),
                .cnt(cnt_q),
                .wr_word(wr_word),
                .buf_wr(buf_wr[gi]),
                .cmp_wr(cmp_wr[gi]),
                .bv_set(wr_fset & reg_wdata[`T16B_BV_CMP0 + gi]),
                .bv_clr(wr_fclr & reg_wdata[`T16B_BV_CMP0 + gi]),
                .update_go(update_go),
                .flag_clr(wr_intfl & reg_wdata[`T16B_IE_CMP0 + gi]),
                .cmp_q(cmp_all[gi*16 +: 16]),
                .buf_q(buf_all[gi*16 +: 16]),
                .bv_q(bv_all[gi]),
                .flag_q(flag_all[gi])
            );
        end
    endgenerate

    // Read side: low byte of a word hands its high byte to the shared latch
    reg [15:0] rd_word;
    reg rd_is16;
    reg [7:0] rd_byte;
    always @* begin
        rd_word = `T16B_ZERO16;
        rd_is16 = 1'b1;
        rd_ofs = `T16B_A_CMP;
        case (word_base)
            `T16B_A_CNT: rd_word = cnt_q;
            `T16B_A_PER: rd_word = per_q;
            `T16B_A_PERBUF: rd_word = perbuf_q;
            default: rd_is16 = 1'b0;
        endcase
        for (rch = 0; rch < `T16B_NCH; rch = rch + 1) begin
            if (word_base == rd_ofs) begin
                rd_word = cmp_all[rch*16 +: 16];
                rd_is16 = 1'b1;
            end
            if (word_base == rd_ofs + (`T16B_A_CMPBUF - `T16B_A_CMP)) begin
                rd_word = buf_all[rch*16 +: 16];
                rd_is16 = 1'b1;
            end
            rd_ofs = rd_ofs + `T16B_CH_STRIDE;
        end
        // Bits with no storage and unmapped bytes read as zero
        case (reg_addr)
            `T16B_A_FCLR,
            `T16B_A_FSET: rd_byte = {`T16B_ZERO4, bv_all, period_buffer_valid_q};
            `T16B_A_EVCTL: rd_byte = {5'h00, evctl_q};
            `T16B_A_INTEN: rd_byte = {1'b0, ie_cmp_q, 3'h0, ie_ovf_q};
            `T16B_A_INTFL: rd_byte = {1'b0, flag_all, 3'h0, ovf_flag_q};
            `T16B_A_DBG: rd_byte = {7'h00, dbg_run_q};
            `T16B_A_TEMP: rd_byte = temp_q;
            default: rd_byte = rd_is16 ? (hi_byte ? temp_q : rd_word[7:0]) : `T16B_ZERO8;
        endcase
    end

    always @(posedge mclk) begin
        if (rst) begin
            cnt_q <= `T16B_ZERO16;
            per_q <= `T16B_PER_RST;
            perbuf_q <= `T16B_PER_RST;
            period_buffer_valid_q <= 1'b0;
            evctl_q <= 3'h0;
            ie_ovf_q <= 1'b0;
            ie_cmp_q <= 3'h0;
            ovf_flag_q <= 1'b0;
            dbg_run_q <= 1'b0;
            temp_q <= `T16B_ZERO8;
            dir_q <= 1'b0;
            reg_rdata <= `T16B_ZERO8;
        end else begin
            cnt_q <= cnt_d;
            dir_q <= dir_d;
            if (wr_perbuf)
                perbuf_q <= wr_word;
            // Set beats a same-cycle update or clear
            period_buffer_valid_q <= wr_perbuf | (wr_fset & reg_wdata[`T16B_BV_PER]) |
                       (period_buffer_valid_q & ~update_go & ~(wr_fclr & reg_wdata[`T16B_BV_PER]));
            if (wr_per)
                per_q <= wr_word;
            else if (update_go && period_buffer_valid_q)
                per_q <= perbuf_q;
            // A wrap in the same cycle as a clear keeps the flag set
            ovf_flag_q <= ovf_ev | (ovf_flag_q & ~(wr_intfl & reg_wdata[`T16B_IE_OVF]));
            if (reg_wr && reg_addr == `T16B_A_EVCTL)
                evctl_q <= reg_wdata[`T16B_EV_ACT_HI:`T16B_EV_COUNT_ON_EVENT_ENABLE];
            if (reg_wr && reg_addr == `T16B_A_INTEN) begin
                ie_ovf_q <= reg_wdata[`T16B_IE_OVF];
                ie_cmp_q <= reg_wdata[`T16B_IE_CMP0 +: 3];
            end
            if (reg_wr && reg_addr == `T16B_A_DBG)
                dbg_run_q <= reg_wdata[`T16B_DBG_RUN];
            // Shared latch: direct write, low-byte write, or low-byte read
            if (reg_wr && (reg_addr == `T16B_A_TEMP || (rd_is16 && !hi_byte)))
                temp_q <= reg_wdata;
            else if (reg_rd && rd_is16 && !hi_byte)
                temp_q <= rd_word[15:8];
            if (reg_rd)
                reg_rdata <= rd_byte;
        end
    end

    // Requests are levels: they stand until software clears the flag or enable
    assign irq_ovf = ovf_flag_q & ie_ovf_q;
    assign irq_cmp = flag_all & ie_cmp_q;
    assign count_down = dir_q;
endmodule

// File: t16b_timer_monitor.sv
// Concurrent checks on the timer register port and request outputs
`timescale 1ns/10ps
module t16b_timer_monitor (
    input wire mclk,
    input wire rst,
    input wire [5:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    input wire event_in,
    input wire prescale_tick,
    input wire timer_enable,
    input wire [2:0] waveform_mode,
    input wire lock_update,
    input wire force_update,
    input wire debug_halt,
    input wire irq_ovf,
    input wire [2:0] irq_cmp,
    input wire count_down
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_temp_wr;
        reg_wr && reg_addr == 6'h0f && !timer_enable && !force_update;
    endsequence
    sequence s_per_hi_wr;
        reg_wr && reg_addr == 6'h27 && !timer_enable && !force_update;
    endsequence
    sequence s_per_lo_rd;
        reg_rd && reg_addr == 6'h26;
    endsequence
    // Only a flag or enable write may take a request away
    property p_cmp_sticky;
        |($past(irq_cmp) & ~irq_cmp) |-> $past(reg_wr) &&
            ($past(reg_addr) == 6'h0a || $past(reg_addr) == 6'h0b);
    endproperty
    property p_ovf_sticky;
        $fell(irq_ovf) |-> $past(reg_wr) &&
            ($past(reg_addr) == 6'h0a || $past(reg_addr) == 6'h0b);
    endproperty
    property p_rd_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    property p_unmapped;
        reg_rd && reg_addr == 6'h10 |=> reg_rdata == 8'h00;
    endproperty
    property p_irq_off;
        reg_wr && reg_addr == 6'h0a && reg_wdata == 8'h00 |=> !irq_ovf && irq_cmp == 3'h0;
    endproperty
    property p_temp_rd;
        s_temp_wr ##1 (reg_rd && reg_addr == 6'h0f) |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    property p_per16;
        s_temp_wr ##1 s_per_hi_wr ##1 s_per_lo_rd |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    property p_fset;
        (reg_wr && reg_addr == 6'h07 && !timer_enable && !force_update) ##1
            (reg_rd && reg_addr == 6'h07) |=> reg_rdata[7:4] == 4'h0 &&
            (reg_rdata[3:0] & $past(reg_wdata[3:0], 2)) == $past(reg_wdata[3:0], 2);
    endproperty
    a_cmp_sticky: assert property (p_cmp_sticky) else $error("compare request lost");
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow request lost");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_irq_off: assert property (p_irq_off) else $error("request without enable");
    a_temp_rd: assert property (p_temp_rd) else $error("temp byte lost");
    a_per16: assert property (p_per16) else $error("word write not joined");
    a_fset: assert property (p_fset) else $error("set write failed");
endmodule
bind t16b_timer t16b_timer_monitor i_mon (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .event_in(event_in), .prescale_tick(prescale_tick), .timer_enable(timer_enable),
    .waveform_mode(waveform_mode), .lock_update(lock_update), .force_update(force_update),
    .debug_halt(debug_halt), .irq_ovf(irq_ovf), .irq_cmp(irq_cmp), .count_down(count_down));

// File: tb_timer16_buffer_event_irq_regs.sv
// Self-checking bench for the 16-bit timer register block
`timescale 1ns/10ps
module tb_timer16_buffer_event_irq_regs;
    logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, event_in = 0, prescale_tick = 0;
    logic timer_enable = 0, lock_update = 0, force_update = 0, debug_halt = 0;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] lo;
    logic [5:0] rst_map [6] = '{6'h07, 6'h09, 6'h0a, 6'h0b, 6'h0e, 6'h0f};
    // Counter and compares both reset to zero, so the compare flags set at once
    logic [7:0] rst_exp [6] = '{8'h00, 8'h00, 8'h00, 8'h70, 8'h00, 8'h00};
    logic [2:0] waveform_mode = 3'h0;
    wire [7:0] reg_rdata;
    wire irq_ovf, count_down;
    wire [2:0] irq_cmp;
    int err_total = 0, compares = 0, cyc = 0;
    t16b_timer i_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_in(event_in),
        .prescale_tick(prescale_tick), .timer_enable(timer_enable),
        .waveform_mode(waveform_mode),
        .lock_update(lock_update), .force_update(force_update), .debug_halt(debug_halt),
        .irq_ovf(irq_ovf), .irq_cmp(irq_cmp), .count_down(count_down));
    initial begin
        forever #2 mclk = ~mclk;
    end
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // The whole run needs under a thousand cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_total++;
            conclude();
        end
    end
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask
    // Strobes stay up until the next task takes over, so accesses run back to back
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        reg_rd = 0;
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge mclk) #1;
    endtask
    task automatic rd(input logic [5:0] a);
        reg_wr = 0;
        reg_rd = 1;
        reg_addr = a;
        @(posedge mclk) #1;
    endtask
    task automatic chk(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
        rd(a);
        cmp({8'h00, reg_rdata & m}, {8'h00, e});
    endtask
    task automatic chk16(input logic [5:0] a, input logic [15:0] e);
        rd(a);
        lo = reg_rdata;
        rd(a + 6'h01);
        cmp({reg_rdata, lo}, e);
    endtask
    task automatic wr16(input logic [5:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 6'h01, v[15:8]);
    endtask
    task automatic idle(input int n);
        reg_wr = 0;
        reg_rd = 0;
        repeat (n) @(posedge mclk) #1;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            prescale_tick = 1;
            idle(1);
            prescale_tick = 0;
            idle(1);
        end
    endtask
    // Pulses are kept well above the synchroniser's minimum width
    task automatic evp(input int n);
        repeat (n) begin
            event_in = 1;
            idle(6);
            event_in = 0;
            idle(6);
        end
    endtask
    task automatic upd;
        force_update = 1;
        idle(1);
        force_update = 0;
    endtask
    task automatic done(input string s);
        $display("test %0s finished", s);
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        #1;
        rst = 0;
        foreach (rst_map[i]) chk(rst_map[i], 8'hff, rst_exp[i]);
        chk16(6'h20, 16'h0000);
        chk16(6'h26, 16'hffff);
        done("reset");
        wr(6'h09, 8'hff);
        chk(6'h09, 8'hff, 8'h07);
        wr(6'h0a, 8'hff);
        chk(6'h0a, 8'hff, 8'h71);
        wr(6'h0a, 8'h00);
        wr(6'h0e, 8'hff);
        chk(6'h0e, 8'hff, 8'h01);
        wr(6'h0f, 8'ha5);
        chk(6'h0f, 8'hff, 8'ha5);
        wr(6'h10, 8'h5a);
        chk(6'h10, 8'hff, 8'h00);
        wr(6'h09, 8'h00);
        wr(6'h0e, 8'h00);
        wr16(6'h26, 16'h1234);
        chk16(6'h26, 16'h1234);
        chk(6'h0f, 8'hff, 8'h12);
        wr(6'h0f, 8'h77);
        wr(6'h27, 8'h56);
        chk(6'h26, 8'hff, 8'h77);
        done("access");
        wr16(6'h38, 16'h0100);
        chk(6'h07, 8'hff, 8'h02);
        wr16(6'h3a, 16'h0101);
        wr16(6'h3c, 16'h0102);
        wr16(6'h36, 16'h1000);
        chk(6'h07, 8'hff, 8'h0f);
        upd;
        chk(6'h07, 8'hff, 8'h00);
        chk16(6'h28, 16'h0100);
        chk16(6'h2a, 16'h0101);
        chk16(6'h26, 16'h1000);
        lock_update = 1;
        wr16(6'h38, 16'h0200);
        upd;
        chk(6'h07, 8'hff, 8'h02);
        chk16(6'h28, 16'h0100);
        lock_update = 0;
        wr(6'h06, 8'h0f);
        chk(6'h07, 8'hff, 8'h00);
        wr(6'h07, 8'h02);
        wr(6'h07, 8'h01);
        chk(6'h07, 8'hff, 8'h03);
        wr(6'h06, 8'h0f);
        done("buffers");
        timer_enable = 1;
        wr16(6'h20, 16'h0000);
        tick(5);
        chk16(6'h20, 16'h0005);
        debug_halt = 1;
        tick(3);
        chk16(6'h20, 16'h0005);
        wr(6'h0e, 8'h01);
        tick(3);
        chk16(6'h20, 16'h0008);
        debug_halt = 0;
        evp(2);
        chk16(6'h20, 16'h0008);
        wr(6'h20, 8'h40);
        prescale_tick = 1;
        wr(6'h21, 8'h00);
        prescale_tick = 0;
        chk16(6'h20, 16'h0040);
        done("counting");
        wr(6'h09, 8'h01);
        wr16(6'h20, 16'h0000);
        evp(3);
        chk16(6'h20, 16'h0003);
        wr(6'h09, 8'h03);
        wr16(6'h20, 16'h0000);
        evp(3);
        chk16(6'h20, 16'h0006);
        wr(6'h09, 8'h05);
        wr16(6'h20, 16'h0000);
        event_in = 1;
        idle(6);
        tick(4);
        event_in = 0;
        idle(6);
        tick(4);
        chk16(6'h20, 16'h0004);
        wr(6'h09, 8'h07);
        wr16(6'h20, 16'h0010);
        tick(3);
        event_in = 1;
        idle(6);
        cmp({15'h0000, count_down}, 16'h0001);
        tick(5);
        event_in = 0;
        idle(6);
        chk16(6'h20, 16'h000e);
        wr(6'h09, 8'h00);
        done("events");
        wr16(6'h28, 16'h0005);
        wr(6'h0b, 8'h70);
        chk(6'h0b, 8'h70, 8'h00);
        wr16(6'h20, 16'h0005);
        idle(2);
        chk(6'h0b, 8'h10, 8'h10);
        wr(6'h0a, 8'h11);
        idle(1);
        cmp({15'h0000, irq_cmp[0]}, 16'h0001);
        wr16(6'h20, 16'h0009);
        idle(2);
        chk(6'h0b, 8'h10, 8'h10);
        wr(6'h0b, 8'h10);
        chk(6'h0b, 8'h10, 8'h00);
        cmp({15'h0000, irq_cmp[0]}, 16'h0000);
        wr16(6'h26, 16'h0003);
        wr16(6'h20, 16'h0003);
        tick(1);
        chk16(6'h20, 16'h0000);
        chk(6'h0b, 8'h01, 8'h01);
        cmp({15'h0000, irq_ovf}, 16'h0001);
        wr(6'h0b, 8'h01);
        chk(6'h0b, 8'h01, 8'h00);
        cmp({15'h0000, irq_ovf}, 16'h0000);
        waveform_mode = 3'h7;
        wr16(6'h20, 16'h0003);
        tick(3);
        chk(6'h0b, 8'h01, 8'h00);
        cmp({15'h0000, count_down}, 16'h0001);
        tick(1);
        chk16(6'h20, 16'h0001);
        chk(6'h0b, 8'h01, 8'h01);
        wr(6'h0b, 8'h01);
        waveform_mode = 3'h0;
        wr(6'h0a, 8'h00);
        idle(1);
        done("flags");
        conclude();
    end
endmodule
